// file: dv/dsw_drive_model.sv
// drive and data separator model: byte times, id fields, index pulse
`timescale 1ns/100ps
module dsw_drive_model (
    input  wire       clock_i,
    input  wire       rst_i,
    input  wire       crc_bad_i,
    input  wire [7:0] track_i,
    output reg        byte_tick_o,
    output reg        id_valid_o,
    output wire [7:0] id_track_o,
    output wire [7:0] id_head_o,
    output wire [7:0] id_sector_o,
    output wire [7:0] id_size_o,
    output wire       id_crc_err_o,
    output wire       index_o
);
    // ----------------------------------------
    // disk rotation
    // ----------------------------------------
    reg [9:0] phase_reg;
    reg [7:0] sec_reg;
    // four clocks a byte, an id every 256 bytes, nine sectors a turn
    always @(posedge clock_i) begin
        if (rst_i) begin
            phase_reg   <= 10'h000;
            sec_reg     <= 8'h09;
            byte_tick_o <= 1'b0;
            id_valid_o  <= 1'b0;
        end else begin
            phase_reg   <= phase_reg + 10'h001;
            byte_tick_o <= (phase_reg[1:0] == 2'h3);
            id_valid_o  <= (phase_reg == 10'h3ff);
            if (phase_reg == 10'h3ff)
                sec_reg <= (sec_reg == 8'h09) ? 8'h01 : sec_reg + 8'h01;
        end
    end
    // id bus shows garbage outside the valid pulse so stale values never match
    assign id_track_o   = id_valid_o ? track_i : ~track_i;
    assign id_head_o    = id_valid_o ? 8'h00 : 8'hff;
    assign id_size_o    = id_valid_o ? 8'h00 : 8'hff;
    assign id_sector_o  = id_valid_o ? sec_reg : ~sec_reg;
    assign id_crc_err_o = id_valid_o & crc_bad_i;
    // index held several clocks so the pin synchroniser catches it
    assign index_o = (sec_reg == 8'h01) && (phase_reg < 10'h010);
endmodule

// file: dv/dsw_props.sv
// assertion checker on the ports of the sector write engine
`timescale 1ns/100ps
module dsw_props (
    input wire       clock_i,
    input wire       rst_i,
    input wire       cmd_start_i,
    input wire       cmd_deleted_i,
    input wire       auto_seek_enable_i,
    input wire       write_protect_i,
    input wire [2:0] reg_addr_i,
    input wire       reg_rd_i,
    input wire [7:0] reg_rdata_o,
    input wire       wr_gate_o,
    input wire       wr_load_o,
    input wire       wr_mark_o,
    input wire [7:0] wr_byte_o,
    input wire       seek_req_o,
    input wire       dma_req_o,
    input wire       irq_o,
    input wire       busy_o
);
    // ----------------------------------------
    // port relations
    // ----------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // the mark byte is loaded inside the gate and follows the command variant
    a_mark_byte: assert property (wr_mark_o |-> wr_load_o && wr_gate_o &&
        wr_byte_o == (cmd_deleted_i ? 8'hf8 : 8'hfb)) else $error("mark byte wrong");
    a_preamble_first: assert property ($rose(wr_gate_o) |-> wr_load_o &&
        wr_byte_o == 8'h00) else $error("gate opened without zero preamble");
    a_load_gated: assert property (wr_load_o |-> wr_gate_o && busy_o)
        else $error("byte loaded outside gate");
    a_wp_blocks: assert property (write_protect_i [*8] |-> !$rose(wr_gate_o))
        else $error("write gate opened while protected");
    a_rdata_quiet: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data outside read answer");
    a_irq_read: assert property (irq_o && reg_rd_i && reg_addr_i == 3'h4 |=> !irq_o)
        else $error("interrupt kept after result read");
    a_start_busy: assert property (cmd_start_i && !busy_o && !irq_o |=> busy_o)
        else $error("start not taken");
    a_seek_auto: assert property (seek_req_o |-> auto_seek_enable_i && busy_o)
        else $error("seek without auto seek");
    a_irq_done: assert property ($rose(irq_o) |-> !wr_gate_o && !dma_req_o)
        else $error("interrupt during execution");
endmodule

// file: dv/dsw_sector_write_engine_tb.sv
// self-checking bench for the sector write engine
`timescale 1ns/100ps
module dsw_sector_write_engine_tb;
    reg        clock_i = 1'b0;
    reg        rst_i = 1'b1;
    reg        cmd_start_i = 1'b0;
    reg        cmd_deleted_i = 1'b0;
    reg        auto_seek_enable_i = 1'b0;
    reg  [7:0] cmd_track_i = 8'h40;
    reg  [7:0] cmd_sector_i = 8'h01;
    reg  [7:0] last_sector_number_i = 8'h09;
    reg        seek_done_i = 1'b0;
    reg        write_protect_i = 1'b0;
    reg        terminal_count_i = 1'b0;
    reg        crc_bad = 1'b0;
    reg        dma_ack_i = 1'b0;
    reg  [7:0] dma_data_i = 8'h00;
    reg  [2:0] reg_addr_i = 3'h0;
    reg  [7:0] reg_wdata_i = 8'h00;
    reg        reg_wr_i = 1'b0;
    reg        reg_rd_i = 1'b0;
    reg        multi_side_enable_i = 1'b0;
    wire       id_no_mark_i = 1'b0;
    wire [1:0] cmd_drive_i = 2'h1;
    wire [7:0] cmd_head_i = 8'h00;
    wire [7:0] cmd_size_i = 8'h00;
    wire       byte_tick_i, id_valid_i, id_crc_err_i, index_i;
    wire [7:0] id_track_i, id_head_i, id_sector_i, id_size_i;
    wire       seek_req_o, wr_gate_o, wr_load_o, wr_mark_o, dma_req_o, irq_o, busy_o;
    wire [7:0] wr_byte_o, reg_rdata_o;
    integer    errors, comparisons, loads, d;
    reg  [7:0] mark_seen, rd;
    reg  [7:0] res [0:6];

    dsw_sector_write_engine dsw_sector_write_engine_i (.*);
    dsw_drive_model dsw_drive_model_i (.clock_i(clock_i), .rst_i(rst_i),
        .crc_bad_i(crc_bad), .track_i(cmd_track_i), .byte_tick_o(byte_tick_i),
        .id_valid_o(id_valid_i), .id_track_o(id_track_i), .id_head_o(id_head_i),
        .id_sector_o(id_sector_i), .id_size_o(id_size_i), .id_crc_err_o(id_crc_err_i),
        .index_o(index_i));

    // ----------------------------------------
    // clock, host side responders
    // ----------------------------------------
    initial forever #5 clock_i = ~clock_i;
    // dma answers each request once; data moves every cycle so stale bytes show
    always @(posedge clock_i) begin
        dma_ack_i <= dma_req_o && !dma_ack_i;
        dma_data_i <= dma_data_i + 8'h01;
        seek_done_i <= seek_req_o && !seek_done_i;
        if (wr_load_o) loads <= loads + 1;
        if (wr_mark_o) mark_seen <= wr_byte_o;
    end

    task check(input [7:0] got, input [7:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task reg_write(input [2:0] a, input [7:0] v);
        begin
            reg_addr_i <= a;
            reg_wdata_i <= v;
            reg_wr_i <= 1'b1;
            @(posedge clock_i);
            reg_wr_i <= 1'b0;
            @(posedge clock_i);
        end
    endtask
    task reg_read(input [2:0] a, output [7:0] v);
        begin
            reg_addr_i <= a;
            reg_rd_i <= 1'b1;
            @(posedge clock_i);
            reg_rd_i <= 1'b0;
            @(posedge clock_i);
            v = reg_rdata_o;
        end
    endtask
    // one command to the interrupt, then all seven result bytes
    task run_cmd(input [7:0] sec, input [7:0] lst, input del, input seek);
        integer n;
        begin
            cmd_track_i <= 8'h40 + sec;
            cmd_sector_i <= sec;
            last_sector_number_i <= lst;
            cmd_deleted_i <= del;
            auto_seek_enable_i <= seek;
            loads = 0;
            cmd_start_i <= 1'b1;
            @(posedge clock_i);
            cmd_start_i <= 1'b0;
            n = 0;
            while (irq_o !== 1'b1 && n < 40000) begin
                @(posedge clock_i);
                n = n + 1;
            end
            if (n >= 40000) errors = errors + 1;
            for (n = 0; n < 7; n = n + 1)
                reg_read(3'h4, res[n]);
        end
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_protect;
        begin
            write_protect_i <= 1'b1;
            run_cmd(8'h03, 8'h09, 1'b0, 1'b0);
            write_protect_i <= 1'b0;
            // let the filtered pin fall before the next search starts
            repeat (4) @(posedge clock_i);
            check({6'h00, res[0][7:6]}, 8'h01);
            check(res[1], 8'h02);
            check(res[3], 8'h43);
            check(loads[7:0], 8'h00);
        end
    endtask
    task t_crc;
        begin
            crc_bad <= 1'b1;
            run_cmd(8'h05, 8'h09, 1'b0, 1'b0);
            crc_bad <= 1'b0;
            check(res[1], 8'h20);
        end
    endtask
    // two sectors to the end of track, normal then deleted mark, with auto seek
    task t_end_track(input del);
        begin
            run_cmd(8'h03, 8'h04, del, 1'b1);
            check({6'h00, res[0][7:6]}, 8'h01);
            check(res[1], 8'h80);
            check(res[5], 8'h04);
            check(loads[8:1], 8'h8d);
            check(mark_seen, del ? 8'hf8 : 8'hfb);
        end
    endtask
    task t_terminal;
        begin
            fork
                run_cmd(8'h02, 8'h05, 1'b0, 1'b0);
                begin
                    wait (wr_mark_o === 1'b1);
                    @(posedge clock_i);
                    terminal_count_i <= 1'b1;
                    repeat (8) @(posedge clock_i);
                    terminal_count_i <= 1'b0;
                end
            join
            check({6'h00, res[0][7:6]}, 8'h00);
            check(res[1], 8'h00);
            check(loads[7:0], 8'h8d);
        end
    endtask
    // side 0 ends on its last sector; side 1 shows only head 0 ids, none matching, so two index
    // pulses end the search while head 1, sector 1 is in hand
    task t_multi;
        begin
            multi_side_enable_i <= 1'b1;
            run_cmd(8'h09, 8'h09, 1'b0, 1'b0);
            multi_side_enable_i <= 1'b0;
            check(res[0], 8'h45);
            check(res[1], 8'h04);
            check(res[2], 8'h00);
            check(res[3], 8'h49);
            check(res[4], 8'h01);
            check(res[5], 8'h01);
        end
    endtask
    // register mode with no data fed: the first data byte is late
    task t_overrun;
        begin
            reg_write(3'h0, 8'h00);
            run_cmd(8'h04, 8'h09, 1'b0, 1'b0);
            check({6'h00, res[0][7:6]}, 8'h01);
            check(res[1], 8'h10);
        end
    endtask

    task print_verdict;
        begin
            $display("comparisons %0d errors %0d", comparisons, errors);
            if (errors == 0 && comparisons > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    // watchdog sized well above six full-turn searches
    initial begin
        #1000000;
        errors = errors + 1;
        print_verdict;
    end
    initial begin
        errors = 0;
        comparisons = 0;
        repeat (4) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        reg_read(3'h7, rd);
        check(rd, 8'h00);
        reg_write(3'h1, 8'h00);
        reg_write(3'h0, 8'h02);
        t_protect;
        t_crc;
        for (d = 0; d < 2; d = d + 1)
            t_end_track(d[0]);
        t_terminal;
        t_multi;
        t_overrun;
        print_verdict;
    end
endmodule
bind dsw_sector_write_engine dsw_props dsw_props_i (.*);

// file: rtl/dsw_consts.vh
// named constants of the disk sector write engine
`ifndef DSW_CONSTS_VH
`define DSW_CONSTS_VH
// register offsets on the plain register port
`define DSW_ADDR_CTRL        3'h0
`define DSW_ADDR_DELAY       3'h1
`define DSW_ADDR_STATUS      3'h2
`define DSW_ADDR_DATA        3'h3
`define DSW_ADDR_RESULT      3'h4
// control register fields
`define DSW_CTRL_PERP        0
`define DSW_CTRL_DMA         1
`define DSW_CTRL_RESET       8'h00
`define DSW_DELAY_RESET      8'h00
// result status fields
`define DSW_TC_NORMAL        2'h0
`define DSW_TC_ABNORMAL      2'h1
`define DSW_S1_END_TRACK     7
`define DSW_S1_CRC           5
`define DSW_S1_OVERRUN       4
`define DSW_S1_NO_DATA       2
`define DSW_S1_WPROT         1
`define DSW_S1_NO_MARK       0
`define DSW_S2_WRONG_TRACK   4
`define DSW_S2_BAD_TRACK     1
`define DSW_BAD_TRACK_ID     8'hff
`define DSW_RESULT_LAST      3'h6
// disk format
`define DSW_GAP2_FULL        8'h16
`define DSW_GAP2_PERP        8'h0a
`define DSW_PREAMBLE_LEN     8'h0c
`define DSW_PREAMBLE_BYTE    8'h00
`define DSW_MARK_NORMAL      8'hfb
`define DSW_MARK_DELETED     8'hf8
`define DSW_SECTOR_BASE      16'h0080
`define DSW_FIRST_SECTOR     8'h01
`define DSW_INDEX_LIMIT      2'h2
// timing
`define DSW_CLK_PERIOD_NS    10
`define DSW_DELAY_UNIT_NS    1000
`define DSW_DELAY_UNIT_CYC   (`DSW_DELAY_UNIT_NS / `DSW_CLK_PERIOD_NS)
`define DSW_SYNC_DEPTH       3
`endif

// file: rtl/dsw_sector_write_engine.v
// sector write engine: search, write, termination and result bytes
`timescale 1ns/100ps
`include "dsw_consts.vh"
module dsw_sector_write_engine (
    input  wire        clock_i,
    input  wire        rst_i,
    // command parameters, held while busy
    input  wire        cmd_start_i,
    input  wire        cmd_deleted_i,
    input  wire        multi_side_enable_i,
    input  wire        auto_seek_enable_i,
    input  wire [1:0]  cmd_drive_i,
    input  wire [7:0]  cmd_track_i,
    input  wire [7:0]  cmd_head_i,
    input  wire [7:0]  cmd_sector_i,
    input  wire [7:0]  cmd_size_i,
    input  wire [7:0]  last_sector_number_i,
    // seek helper
    output reg         seek_req_o,
    input  wire        seek_done_i,
    // data separator, same clock
    input  wire        byte_tick_i,
    input  wire        id_valid_i,
    input  wire        id_crc_err_i,
    input  wire        id_no_mark_i,
    input  wire [7:0]  id_track_i,
    input  wire [7:0]  id_head_i,
    input  wire [7:0]  id_sector_i,
    input  wire [7:0]  id_size_i,
    // drive pins
    input  wire        index_i,
    input  wire        write_protect_i,
    input  wire        terminal_count_i,
    // write path
    output reg         wr_gate_o,
    output reg         wr_load_o,
    output reg         wr_mark_o,
    output reg  [7:0]  wr_byte_o,
    // dma
    output reg         dma_req_o,
    input  wire        dma_ack_i,
    input  wire [7:0]  dma_data_i,
    // register port
    input  wire [2:0]  reg_addr_i,
    input  wire [7:0]  reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output reg  [7:0]  reg_rdata_o,
    output reg         irq_o,
    output reg         busy_o
);

// ---------------------------------------------------------------
// states
// ---------------------------------------------------------------
localparam [3:0] ST_IDLE   = 4'h0;
localparam [3:0] ST_DELAY  = 4'h1;
localparam [3:0] ST_SEEK   = 4'h2;
localparam [3:0] ST_SEARCH = 4'h3;
localparam [3:0] ST_GAP    = 4'h4;
localparam [3:0] ST_PREAMB = 4'h5;
localparam [3:0] ST_MARK   = 4'h6;
localparam [3:0] ST_DATA   = 4'h7;
localparam [3:0] ST_NEXT   = 4'h8;
localparam [3:0] ST_RESULT = 4'h9;

reg  [3:0]  state_reg;
reg  [7:0]  ctrl_reg;
reg  [7:0]  delay_reg;
reg  [23:0] wait_reg;
reg  [15:0] count_reg;
reg  [1:0]  index_cnt_reg;
reg         id_seen_reg;
reg         track_miss_reg;
reg         bad_track_reg;
reg  [1:0]  code_reg;
reg  [7:0]  st1_reg;
reg  [7:0]  st2_reg;
reg  [7:0]  cur_head_reg;
reg  [7:0]  cur_sector_reg;
reg  [7:0]  hold_reg;
reg         hold_full_reg;
reg  [7:0]  last_reg;
reg         tc_seen_reg;
reg  [2:0]  res_ptr_reg;
reg  [2:0]  pin_filt_reg;
reg  [2:0]  pin_prev_reg;
wire [2:0]  pin_raw;
wire [2:0]  pin_s2;
wire [2:0]  pin_s3;

// register port decode, shared by read and write paths
function hit;
    input [2:0] addr;
    input [2:0] target;
    begin
        hit = (addr == target);
    end
endfunction

// result byte selected by index
function [7:0] result_byte;
    input [2:0] idx;
    begin
        case (idx)
            3'h0:    result_byte = {code_reg, 3'h0, cur_head_reg[0], cmd_drive_i};
            3'h1:    result_byte = st1_reg;
            3'h2:    result_byte = st2_reg;
            3'h3:    result_byte = cmd_track_i;
            3'h4:    result_byte = cur_head_reg;
            3'h5:    result_byte = cur_sector_reg;
            3'h6:    result_byte = cmd_size_i;
            default: result_byte = 8'h00;
        endcase
    end
endfunction

// ---------------------------------------------------------------
// pin synchronisers
// ---------------------------------------------------------------
assign pin_raw = {terminal_count_i, write_protect_i, index_i};

// a change counts only once stages two and three agree, so a glitch
// caught by one sample never reaches the sequencer
genvar g;
generate
    for (g = 0; g < `DSW_SYNC_DEPTH; g = g + 1) begin : g_sync
        reg [2:0] sh_reg;
        always @(posedge clock_i) begin
            if (rst_i) begin
                sh_reg <= 3'h0;
                pin_filt_reg[g] <= 1'b0;
                pin_prev_reg[g] <= 1'b0;
            end else begin
                sh_reg <= {sh_reg[1:0], pin_raw[g]};
                if (pin_s2[g] == pin_s3[g]) begin
                    pin_filt_reg[g] <= pin_s3[g];
                end
                pin_prev_reg[g] <= pin_filt_reg[g];
            end
        end
        assign pin_s2[g] = sh_reg[1];
        assign pin_s3[g] = sh_reg[2];
    end
endgenerate

wire index_rise = pin_filt_reg[0] & ~pin_prev_reg[0];
wire wprot      = pin_filt_reg[1];
wire tc_level   = pin_filt_reg[2];

// ---------------------------------------------------------------
// derived terms
// ---------------------------------------------------------------
wire        host_wr  = reg_wr_i & hit(reg_addr_i, `DSW_ADDR_DATA);
wire        res_rd   = reg_rd_i & hit(reg_addr_i, `DSW_ADDR_RESULT);
wire        feeding  = (state_reg == ST_GAP) | (state_reg == ST_PREAMB) |
                       (state_reg == ST_MARK) | (state_reg == ST_DATA);
wire        id_match = (id_track_i == cmd_track_i) & (id_head_i == cur_head_reg) &
                       (id_sector_i == cur_sector_reg) & (id_size_i == cmd_size_i);
wire [15:0] sec_len  = `DSW_SECTOR_BASE << cmd_size_i[2:0];
wire [7:0]  gap_len  = ctrl_reg[`DSW_CTRL_PERP] ? `DSW_GAP2_PERP : `DSW_GAP2_FULL;
// full product kept, then cut on purpose to the wait counter width
wire [31:0] delay_full = delay_reg * `DSW_DELAY_UNIT_CYC;
wire [23:0] delay_cyc  = delay_full[23:0];
wire        byte_in  = dma_ack_i | host_wr;
wire [7:0]  byte_val = dma_ack_i ? dma_data_i : reg_wdata_i;

// ---------------------------------------------------------------
// register port
// ---------------------------------------------------------------
// read data stands in the cycle after the strobe only; a result read
// outside the result phase returns zero and moves nothing
always @(posedge clock_i) begin
    if (rst_i) begin
        ctrl_reg    <= `DSW_CTRL_RESET;
        delay_reg   <= `DSW_DELAY_RESET;
        reg_rdata_o <= 8'h00;
    end else begin
        if (reg_wr_i & hit(reg_addr_i, `DSW_ADDR_CTRL)) begin
            ctrl_reg <= reg_wdata_i;
        end
        if (reg_wr_i & hit(reg_addr_i, `DSW_ADDR_DELAY)) begin
            delay_reg <= reg_wdata_i;
        end
        reg_rdata_o <= 8'h00;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `DSW_ADDR_CTRL:   reg_rdata_o <= ctrl_reg;
                `DSW_ADDR_DELAY:  reg_rdata_o <= delay_reg;
                `DSW_ADDR_STATUS: reg_rdata_o <= {busy_o, irq_o, hold_full_reg,
                                                  dma_req_o, state_reg};
                `DSW_ADDR_RESULT: reg_rdata_o <= (state_reg == ST_RESULT) ?
                                                 result_byte(res_ptr_reg) : 8'h00;
                default:          reg_rdata_o <= 8'h00;
            endcase
        end
    end
end

// ---------------------------------------------------------------
// sequencer
// ---------------------------------------------------------------
always @(posedge clock_i) begin
    if (rst_i) begin
        state_reg      <= ST_IDLE;
        wait_reg       <= 24'h0;
        count_reg      <= 16'h0;
        index_cnt_reg  <= 2'h0;
        id_seen_reg    <= 1'b0;
        track_miss_reg <= 1'b0;
        bad_track_reg  <= 1'b0;
        code_reg       <= `DSW_TC_NORMAL;
        st1_reg        <= 8'h00;
        st2_reg        <= 8'h00;
        cur_head_reg   <= 8'h00;
        cur_sector_reg <= 8'h00;
        hold_reg       <= 8'h00;
        hold_full_reg  <= 1'b0;
        last_reg       <= 8'h00;
        tc_seen_reg    <= 1'b0;
        res_ptr_reg    <= 3'h0;
        seek_req_o     <= 1'b0;
        wr_gate_o      <= 1'b0;
        wr_load_o      <= 1'b0;
        wr_mark_o      <= 1'b0;
        wr_byte_o      <= 8'h00;
        dma_req_o      <= 1'b0;
        irq_o          <= 1'b0;
        busy_o         <= 1'b0;
    end else begin
        wr_load_o <= 1'b0;
        wr_mark_o <= 1'b0;
        // one byte buffered ahead of the disk; request while empty
        if (feeding & byte_in & ~hold_full_reg) begin
            hold_reg      <= byte_val;
            hold_full_reg <= 1'b1;
        end
        dma_req_o <= feeding & ~hold_full_reg & ~byte_in & ~tc_seen_reg &
                     ctrl_reg[`DSW_CTRL_DMA];
        if (feeding & tc_level) begin
            tc_seen_reg <= 1'b1;
        end
        case (state_reg)
            ST_IDLE: begin
                if (cmd_start_i) begin
                    busy_o         <= 1'b1;
                    irq_o          <= 1'b0;
                    st1_reg        <= 8'h00;
                    st2_reg        <= 8'h00;
                    code_reg       <= `DSW_TC_NORMAL;
                    tc_seen_reg    <= 1'b0;
                    hold_full_reg  <= 1'b0;
                    cur_head_reg   <= cmd_head_i;
                    cur_sector_reg <= cmd_sector_i;
                    wait_reg       <= 24'h0;
                    state_reg      <= ST_DELAY;
                end
            end
            ST_DELAY: begin
                wait_reg <= wait_reg + 24'h1;
                if (wait_reg >= delay_cyc) begin
                    seek_req_o <= auto_seek_enable_i;
                    state_reg  <= auto_seek_enable_i ? ST_SEEK : ST_SEARCH;
                    index_cnt_reg  <= 2'h0;
                    id_seen_reg    <= 1'b0;
                    track_miss_reg <= 1'b0;
                    bad_track_reg  <= 1'b0;
                end
            end
            ST_SEEK: begin
                // seek and its sense step are run here, not by separate commands
                if (seek_done_i) begin
                    seek_req_o <= 1'b0;
                    state_reg  <= ST_SEARCH;
                end
            end
            ST_SEARCH: begin
                if (index_rise) begin
                    index_cnt_reg <= index_cnt_reg + 2'h1;
                end
                // search errors end the command before any byte of the sought sector is written
                if (wprot) begin
                    st1_reg[`DSW_S1_WPROT] <= 1'b1;
                    code_reg  <= `DSW_TC_ABNORMAL;
                    state_reg <= ST_RESULT;
                end else if (host_wr) begin
                    // a data write while searching aborts, e.g. with no disk
                    code_reg  <= `DSW_TC_ABNORMAL;
                    state_reg <= ST_RESULT;
                end else if (id_valid_i & id_crc_err_i) begin
                    st1_reg[`DSW_S1_CRC] <= 1'b1;
                    code_reg  <= `DSW_TC_ABNORMAL;
                    state_reg <= ST_RESULT;
                end else if (id_valid_i & id_match) begin
                    count_reg <= {8'h00, gap_len};
                    state_reg <= ST_GAP;
                end else if (index_cnt_reg == `DSW_INDEX_LIMIT) begin
                    st1_reg[`DSW_S1_NO_MARK] <= ~id_seen_reg;
                    st1_reg[`DSW_S1_NO_DATA] <= id_seen_reg;
                    st2_reg[`DSW_S2_WRONG_TRACK] <= track_miss_reg & ~bad_track_reg;
                    st2_reg[`DSW_S2_BAD_TRACK]   <= bad_track_reg;
                    code_reg  <= `DSW_TC_ABNORMAL;
                    state_reg <= ST_RESULT;
                end else if (id_valid_i) begin
                    // keep looking at later sectors
                    id_seen_reg <= 1'b1;
                    if (id_track_i != cmd_track_i) begin
                        track_miss_reg <= 1'b1;
                        bad_track_reg  <= (id_track_i == `DSW_BAD_TRACK_ID);
                    end
                end else if (id_no_mark_i) begin
                    id_seen_reg <= id_seen_reg;
                end
            end
            ST_GAP: begin
                if (byte_tick_i) begin
                    count_reg <= count_reg - 16'h1;
                    if (count_reg == 16'h1) begin
                        count_reg <= {8'h00, `DSW_PREAMBLE_LEN};
                        state_reg <= ST_PREAMB;
                    end
                end
            end
            ST_PREAMB: begin
                if (byte_tick_i) begin
                    wr_gate_o <= 1'b1;
                    wr_load_o <= 1'b1;
                    wr_byte_o <= `DSW_PREAMBLE_BYTE;
                    count_reg <= count_reg - 16'h1;
                    if (count_reg == 16'h1) begin
                        state_reg <= ST_MARK;
                    end
                end
            end
            ST_MARK: begin
                if (byte_tick_i) begin
                    wr_load_o <= 1'b1;
                    wr_mark_o <= 1'b1;
                    wr_byte_o <= cmd_deleted_i ? `DSW_MARK_DELETED : `DSW_MARK_NORMAL;
                    count_reg <= sec_len;
                    state_reg <= ST_DATA;
                end
            end
            ST_DATA: begin
                if (byte_tick_i) begin
                    wr_load_o <= 1'b1;
                    count_reg <= count_reg - 16'h1;
                    if (hold_full_reg) begin
                        wr_byte_o     <= hold_reg;
                        last_reg      <= hold_reg;
                        // a byte arriving as the buffer drains is kept, not lost
                        hold_full_reg <= byte_in;
                        if (byte_in) begin
                            hold_reg <= byte_val;
                        end
                    end else begin
                        // late byte: repeat the last good one so the field closes
                        wr_byte_o <= last_reg;
                        if (~tc_seen_reg) begin
                            // gate closes after this byte, in the result state, or in ST_NEXT if it was the sector's last
                            st1_reg[`DSW_S1_OVERRUN] <= 1'b1;
                            code_reg  <= `DSW_TC_ABNORMAL;
                            state_reg <= ST_RESULT;
                        end
                    end
                    if (count_reg == 16'h1) begin
                        state_reg <= ST_NEXT;
                    end
                end
            end
            ST_NEXT: begin
                wr_gate_o <= 1'b0;
                // current sector stays in the result if this is the end
                if (tc_seen_reg) begin
                    code_reg  <= `DSW_TC_NORMAL;
                    state_reg <= ST_RESULT;
                end else if (cur_sector_reg == last_sector_number_i) begin
                    if (multi_side_enable_i & ~cur_head_reg[0]) begin
                        cur_head_reg   <= 8'h01;
                        cur_sector_reg <= `DSW_FIRST_SECTOR;
                        index_cnt_reg  <= 2'h0;
                        state_reg      <= ST_SEARCH;
                    end else begin
                        st1_reg[`DSW_S1_END_TRACK] <= 1'b1;
                        code_reg  <= `DSW_TC_ABNORMAL;
                        state_reg <= ST_RESULT;
                    end
                end else begin
                    cur_sector_reg <= cur_sector_reg + 8'h1;
                    index_cnt_reg  <= 2'h0;
                    state_reg      <= ST_SEARCH;
                end
            end
            ST_RESULT: begin
                // cur head and sector still name the sector in hand
                wr_gate_o <= 1'b0;
                busy_o <= 1'b0;
                if (res_rd) begin
                    irq_o       <= 1'b0;
                    res_ptr_reg <= res_ptr_reg + 3'h1;
                    if (res_ptr_reg == `DSW_RESULT_LAST) begin
                        res_ptr_reg <= 3'h0;
                        state_reg   <= ST_IDLE;
                    end
                end
                // raised on entry and held until the first result read; a read
                // in the entry cycle does not swallow it
                if (busy_o) begin
                    irq_o <= 1'b1;
                end
            end
            default: begin
                state_reg <= ST_IDLE;
            end
        endcase
    end
end

endmodule
